/* hdl/uepirq_pkg.sv */
// Behaviour
// - Any status change pulses the endpoint event strobe.
// - Status registers are 8-bit, writes ignored.
// - Zero written to clear bit clears status.
// - Unsupported endpoint bits read as invalid zero.
// - Bulk-in NAK on IN sets bits 7, 5.
// - Bulk-in FIFO toggle sets bits 6, 4.
// - First bulk-in FIFO write clears toggled flag.
// - Written data goes on the following IN token.
// - Interrupt-in host receipt sets bit 0.
// - First interrupt-in FIFO write clears bit 0.
// - Bulk-in pairs are endpoints 1, 3; interrupt 7.
// - Both bulk-out FIFOs full sets bits 7, 3.
// - Zero-length packet sets bits 6, 2.
// - Bulk-out NAK on OUT sets bits 5, 1.
// - Receive flag clears when CPU FIFO empties.
// - Request held while SIE FIFO holds data.
// - Mask bit one suppresses summary interrupt contribution.
package uepirq_pkg;

    localparam logic [31:0] UEPIRQ_IN_STATUS_ADDR = 32'h0020_0024;
    localparam logic [31:0] UEPIRQ_OUT_STATUS_ADDR = 32'h0020_0026;
    localparam logic [31:0] UEPIRQ_IN_CLEAR_ADDR = 32'h0020_0034;
    localparam logic [31:0] UEPIRQ_OUT_CLEAR_ADDR = 32'h0020_0036;
    localparam logic [31:0] UEPIRQ_IN_MASK_ADDR = 32'h0020_0032;
    localparam logic [31:0] UEPIRQ_OUT_MASK_ADDR = 32'h0020_0030;
    localparam logic [31:0] UEPIRQ_SUPPORT_ADDR = 32'h0020_0038;

    localparam logic [7:0] UEPIRQ_STATUS_RESET = 8'h00;
    localparam logic [7:0] UEPIRQ_MASK_RESET = 8'h00;
    localparam logic [7:0] UEPIRQ_IN_USED = 8'hf1;

    localparam int UEPIRQ_IN_NAK1 = 5;
    localparam int UEPIRQ_IN_DT1 = 4;
    localparam int UEPIRQ_IN_NAK2 = 7;
    localparam int UEPIRQ_IN_DT2 = 6;
    localparam int UEPIRQ_INT_DT = 0;
    localparam int UEPIRQ_OUT_GROUP = 4;
    localparam int UEPIRQ_OUT_DT = 0;
    localparam int UEPIRQ_OUT_NAK = 1;
    localparam int UEPIRQ_OUT_NL = 2;
    localparam int UEPIRQ_OUT_FL = 3;

    // Support bits: 0 ep1, 1 ep3, 2 ep7, 3 ep2, 4 ep4.
    localparam int UEPIRQ_SUP_EP1 = 0;
    localparam int UEPIRQ_SUP_EP3 = 1;
    localparam int UEPIRQ_SUP_EP7 = 2;
    localparam int UEPIRQ_SUP_EP2 = 3;
    localparam int UEPIRQ_SUP_EP4 = 4;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } uepirq_bus_t;

    // Events from one bulk-out endpoint's FIFO logic.
    typedef struct packed {
        logic both_full;
        logic null_set;
        logic nak;
        logic rx_toggle;
        logic cpu_empty;
        logic sie_has_data;
    } uepirq_out_ev_t;

endpackage

/* hdl/uepirq_in_pair.sv */
`timescale 1ns/1ps
`default_nettype none
// One bulk-in endpoint: NAK flag and FIFO-toggled flag.
module uepirq_in_pair
    import uepirq_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Events
    input wire logic i_nak_set,
    input wire logic i_toggle_set,
    input wire logic i_fifo_write,
    input wire logic i_clr_nak,
    input wire logic i_clr_dt,
    // Flags
    output logic o_nak,
    output logic o_dt
);
    logic nak_ff;
    logic dt_ff;
    logic nxt_nak;
    logic nxt_dt;

    // Sets win over any clear in the same cycle.
    always_comb begin
        nxt_nak = i_nak_set | (nak_ff & ~i_clr_nak);
        nxt_dt = i_toggle_set | (dt_ff & ~i_clr_dt & ~i_fifo_write);
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            nak_ff <= 1'b0;
            dt_ff <= 1'b0;
        end else begin
            nak_ff <= nxt_nak;
            dt_ff <= nxt_dt;
        end
    end

    assign o_nak = nak_ff;
    assign o_dt = dt_ff;
endmodule // uepirq_in_pair
`default_nettype wire

/* hdl/uepirq_out_group.sv */
`timescale 1ns/1ps
`default_nettype none
// One bulk-out endpoint: four flags and its request level.
module uepirq_out_group
    import uepirq_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Events and clears
    input wire uepirq_out_ev_t i_ev,
    input wire logic [3:0] i_clr,
    // Flags
    output logic [3:0] o_flags,
    output logic o_rx_req
);
    logic [3:0] flags_ff;
    logic [3:0] nxt_flags;
    logic pend_null_ff;
    logic nxt_pend_null;

    always_comb begin
        nxt_flags = flags_ff & ~i_clr;
        nxt_pend_null = pend_null_ff;
        if (i_ev.rx_toggle) begin
            nxt_flags[UEPIRQ_OUT_FL] = 1'b0;
        end
        if (i_ev.both_full) begin
            nxt_flags[UEPIRQ_OUT_FL] = 1'b1;
        end
        if (i_ev.null_set && i_ev.cpu_empty) begin
            nxt_flags[UEPIRQ_OUT_NL] = 1'b1;
        end else if (i_ev.null_set) begin
            nxt_pend_null = 1'b1;
        end else if (pend_null_ff && i_ev.cpu_empty) begin
            nxt_flags[UEPIRQ_OUT_NL] = 1'b1;
            nxt_pend_null = 1'b0;
        end
        if (i_ev.nak) begin
            nxt_flags[UEPIRQ_OUT_NAK] = 1'b1;
        end
        if (i_ev.cpu_empty) begin
            nxt_flags[UEPIRQ_OUT_DT] = 1'b0;
        end
        if (i_ev.rx_toggle) begin
            nxt_flags[UEPIRQ_OUT_DT] = 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            flags_ff <= 4'h0;
            pend_null_ff <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            pend_null_ff <= nxt_pend_null;
        end
    end

    assign o_flags = flags_ff;
    assign o_rx_req = flags_ff[UEPIRQ_OUT_DT] | i_ev.sie_has_data;
endmodule // uepirq_out_group
`default_nettype wire

/* hdl/uepirq_top.sv */
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Endpoint interrupt status for bulk-in, interrupt-in and bulk-out endpoints.
module uepirq_top
    import uepirq_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Register port
    input wire logic [31:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Bulk-in and interrupt-in events, index 0 ep1, index 1 ep3
    input wire logic [1:0] i_bulk_in_nak,
    input wire logic [1:0] i_bulk_in_toggle,
    input wire logic [1:0] i_bulk_in_fifo_write,
    input wire logic i_int_in_sent,
    input wire logic i_int_in_fifo_write,
    // Bulk-out events, index 0 ep2, index 1 ep4
    input wire uepirq_out_ev_t [1:0] i_out_ev,
    // Current interface setting support per endpoint
    input wire logic [4:0] i_if_support,
    // Outputs
    output logic o_endpoint_event_strobe,
    output logic o_function_irq_primary,
    output logic o_function_irq_secondary,
    output logic [1:0] o_out_received
);
    logic [7:0] in_mask_ff;
    logic [7:0] out_mask_ff;
    logic [4:0] map_ff;
    logic int_dt_ff;
    logic [7:0] rdata_ff;
    logic strobe_ff;
    logic irq0_ff;
    logic irq1_ff;
    logic [1:0] rcv_ff;
    logic [7:0] in_prev_ff;
    logic [7:0] out_prev_ff;
    logic [7:0] nxt_in_mask;
    logic [7:0] nxt_out_mask;
    logic [4:0] nxt_map;
    logic nxt_int_dt;
    logic [7:0] nxt_rdata;
    logic [7:0] in_clr;
    logic [7:0] out_clr;
    logic [1:0] in_nak;
    logic [1:0] in_dt;
    logic [7:0] out_flags;
    logic [1:0] rx_req;
    logic [7:0] in_stat;
    logic [7:0] out_stat;
    logic [4:0] valid;

    always_comb begin
        in_clr = 8'h00;
        out_clr = 8'h00;
        if (i_wr && i_addr == UEPIRQ_IN_CLEAR_ADDR) begin
            in_clr = ~i_wdata;
        end else if (i_wr && i_addr == UEPIRQ_OUT_CLEAR_ADDR) begin
            out_clr = ~i_wdata;
        end
    end

    uepirq_in_pair u_in_ep1 (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_nak_set(i_bulk_in_nak[0]),
        .i_toggle_set(i_bulk_in_toggle[0]),
        .i_fifo_write(i_bulk_in_fifo_write[0]),
        .i_clr_nak(in_clr[UEPIRQ_IN_NAK1]),
        .i_clr_dt(in_clr[UEPIRQ_IN_DT1]),
        .o_nak(in_nak[0]),
        .o_dt(in_dt[0])
    );
    uepirq_in_pair u_in_ep3 (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_nak_set(i_bulk_in_nak[1]),
        .i_toggle_set(i_bulk_in_toggle[1]),
        .i_fifo_write(i_bulk_in_fifo_write[1]),
        .i_clr_nak(in_clr[UEPIRQ_IN_NAK2]),
        .i_clr_dt(in_clr[UEPIRQ_IN_DT2]),
        .o_nak(in_nak[1]),
        .o_dt(in_dt[1])
    );

    uepirq_out_group u_out_ep2 (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_ev(i_out_ev[0]),
        .i_clr(out_clr[3:0]),
        .o_flags(out_flags[3:0]),
        .o_rx_req(rx_req[0])
    );
    uepirq_out_group u_out_ep4 (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_ev(i_out_ev[1]),
        .i_clr(out_clr[7:4]),
        .o_flags(out_flags[7:4]),
        .o_rx_req(rx_req[1])
    );

    assign valid = map_ff & i_if_support;

    always_comb begin
        in_stat = 8'h00;
        in_stat[UEPIRQ_IN_NAK1] = in_nak[0] & valid[UEPIRQ_SUP_EP1];
        in_stat[UEPIRQ_IN_DT1] = in_dt[0] & valid[UEPIRQ_SUP_EP1];
        in_stat[UEPIRQ_IN_NAK2] = in_nak[1] & valid[UEPIRQ_SUP_EP3];
        in_stat[UEPIRQ_IN_DT2] = in_dt[1] & valid[UEPIRQ_SUP_EP3];
        in_stat[UEPIRQ_INT_DT] = int_dt_ff & valid[UEPIRQ_SUP_EP7];
        out_stat[3:0] = out_flags[3:0] & {4{valid[UEPIRQ_SUP_EP2]}};
        out_stat[7:4] = out_flags[7:4] & {4{valid[UEPIRQ_SUP_EP4]}};
    end

    always_comb begin
        nxt_int_dt = i_int_in_sent
            | (int_dt_ff & ~in_clr[UEPIRQ_INT_DT] & ~i_int_in_fifo_write);
        nxt_in_mask = in_mask_ff;
        nxt_out_mask = out_mask_ff;
        nxt_map = map_ff;
        if (i_wr && i_addr == UEPIRQ_IN_MASK_ADDR) begin
            nxt_in_mask = i_wdata & UEPIRQ_IN_USED;
        end else if (i_wr && i_addr == UEPIRQ_OUT_MASK_ADDR) begin
            nxt_out_mask = i_wdata;
        end else if (i_wr && i_addr == UEPIRQ_SUPPORT_ADDR) begin
            nxt_map = i_wdata[4:0];
        end
        nxt_rdata = 8'h00;
        if (i_rd) begin
            if (i_addr == UEPIRQ_IN_STATUS_ADDR) begin
                nxt_rdata = in_stat;
            end else if (i_addr == UEPIRQ_OUT_STATUS_ADDR) begin
                nxt_rdata = out_stat;
            end else if (i_addr == UEPIRQ_IN_MASK_ADDR) begin
                nxt_rdata = in_mask_ff;
            end else if (i_addr == UEPIRQ_OUT_MASK_ADDR) begin
                nxt_rdata = out_mask_ff;
            end else if (i_addr == UEPIRQ_SUPPORT_ADDR) begin
                nxt_rdata = {3'h0, map_ff};
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            in_mask_ff <= UEPIRQ_MASK_RESET;
            out_mask_ff <= UEPIRQ_MASK_RESET;
            map_ff <= 5'h1f;
            int_dt_ff <= 1'b0;
            rdata_ff <= 8'h00;
            strobe_ff <= 1'b0;
            irq0_ff <= 1'b0;
            irq1_ff <= 1'b0;
            rcv_ff <= 2'h0;
            in_prev_ff <= UEPIRQ_STATUS_RESET;
            out_prev_ff <= UEPIRQ_STATUS_RESET;
        end else begin
            in_mask_ff <= nxt_in_mask;
            out_mask_ff <= nxt_out_mask;
            map_ff <= nxt_map;
            int_dt_ff <= nxt_int_dt;
            rdata_ff <= nxt_rdata;
            in_prev_ff <= in_stat;
            out_prev_ff <= out_stat;
            strobe_ff <= (in_stat != in_prev_ff) || (out_stat != out_prev_ff);
            irq0_ff <= |(in_stat & ~in_mask_ff)
                | |(out_stat & ~out_mask_ff & 8'hee);
            irq1_ff <= |(rx_req & ~{out_mask_ff[4], out_mask_ff[0]}
                & {valid[UEPIRQ_SUP_EP4], valid[UEPIRQ_SUP_EP2]});
            rcv_ff <= {out_stat[4], out_stat[0]};
        end
    end

    assign o_rdata = rdata_ff;
    assign o_endpoint_event_strobe = strobe_ff;
    assign o_function_irq_primary = irq0_ff;
    assign o_function_irq_secondary = irq1_ff;
    assign o_out_received = rcv_ff;
endmodule // uepirq_top
`default_nettype wire

/* testbench/uepirq_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module uepirq_assertions
    import uepirq_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Register port
    input wire logic [31:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Events
    input wire logic [1:0] i_bulk_in_nak,
    input wire logic [1:0] i_bulk_in_toggle,
    input wire logic [1:0] i_bulk_in_fifo_write,
    input wire logic i_int_in_sent,
    input wire logic i_int_in_fifo_write,
    input wire uepirq_out_ev_t [1:0] i_out_ev,
    input wire logic [4:0] i_if_support,
    // Outputs
    input wire logic o_endpoint_event_strobe,
    input wire logic o_function_irq_primary,
    input wire logic o_function_irq_secondary,
    input wire logic [1:0] o_out_received
);
    logic [6:0] lvl;
    logic [6:0] lvl_ff;
    logic cause;
    logic sup_move;
    assign lvl = {i_out_ev[1].cpu_empty, i_out_ev[0].cpu_empty, i_if_support};
    assign sup_move = lvl[4:0] != lvl_ff[4:0];
    // Levels count as a cause only in the cycle they move.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            lvl_ff <= 7'h00;
        end else begin
            lvl_ff <= lvl;
        end
    end
    assign cause = (|i_bulk_in_nak) | (|i_bulk_in_toggle) | (|i_bulk_in_fifo_write) | i_int_in_sent
        | i_int_in_fifo_write | i_wr | (|i_out_ev[0][5:2]) | (|i_out_ev[1][5:2]) | (lvl != lvl_ff);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_in_unused: assert property ($past(i_rd) && $past(i_addr) == UEPIRQ_IN_STATUS_ADDR
        |-> o_rdata[3:1] == 3'h0)
        else $error("unused in status bits not zero");
    // A support change unhides stored flags at once, one cycle ahead of the flopped event sources.
    chk_strobe_cause: assert property (o_endpoint_event_strobe |-> $past(cause, 2) || $past(sup_move))
        else $error("event strobe without a cause");
    chk_nak_irq: assert property (i_bulk_in_nak[0] && i_if_support[0] |-> ##[1:2] o_function_irq_primary)
        else $error("bulk in nak raised no request");
    chk_rx_set: assert property (i_out_ev[0].rx_toggle && i_if_support[3] |-> ##[1:2] o_out_received[0])
        else $error("receive flag not set");
    chk_rx_unsup: assert property (!i_if_support[3] [*3] |-> !o_out_received[0])
        else $error("unsupported endpoint flag set");
    chk_rx_clear: assert property (o_out_received[0] && i_out_ev[0].cpu_empty && !i_out_ev[0].rx_toggle
        |-> ##[1:2] !o_out_received[0])
        else $error("receive flag not cleared on empty");
    chk_sec_hold: assert property ((i_out_ev[0].sie_has_data && i_if_support[3]) [*3]
        |-> o_function_irq_secondary)
        else $error("secondary request dropped with data pending");
    cover property (i_rd && i_addr == UEPIRQ_OUT_STATUS_ADDR);
    cover property (o_endpoint_event_strobe);
    cover property (o_function_irq_secondary && !o_out_received[0]);
endmodule // uepirq_assertions
`default_nettype wire

/* testbench/uepirq_sie.sv */
`timescale 1ns/1ps
`default_nettype none
module uepirq_sie
    import uepirq_pkg::*;
(
    // Clock
    input wire logic i_clock,
    // Events toward the block
    output logic [1:0] o_nak,
    output logic [1:0] o_tog,
    output logic o_sent,
    output var uepirq_out_ev_t [1:0] o_ev
);
    initial begin
        o_nak = 2'h0;
        o_tog = 2'h0;
        o_sent = 1'b0;
        o_ev = 12'h082;
    end
    // One-cycle event; k picks the source, n the endpoint.
    task automatic pulse(input int k, input int n);
        @(posedge i_clock);
        case (k)
            0: o_nak[n] <= 1'b1;
            1: o_tog[n] <= 1'b1;
            2: o_sent <= 1'b1;
            3: o_ev[n].nak <= 1'b1;
            4: o_ev[n].null_set <= 1'b1;
            5: o_ev[n].both_full <= 1'b1;
            default: begin
                // Received data always lands in the CPU side first.
                o_ev[n].rx_toggle <= 1'b1;
                o_ev[n].cpu_empty <= 1'b0;
            end
        endcase
        @(posedge i_clock);
        o_nak <= 2'h0;
        o_tog <= 2'h0;
        o_sent <= 1'b0;
        {o_ev[n].both_full, o_ev[n].null_set, o_ev[n].nak, o_ev[n].rx_toggle} <= 4'h0;
    endtask
    task automatic level(input int n, input logic emp, input logic sie);
        @(posedge i_clock);
        o_ev[n].cpu_empty <= emp;
        o_ev[n].sie_has_data <= sie;
    endtask
endmodule // uepirq_sie
`default_nettype wire

/* testbench/uepirq_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module uepirq_top_test
    import uepirq_pkg::*;
;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [31:0] i_addr = 32'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [2:0] fw = 3'h0;
    logic [4:0] i_if_support = 5'h1f;
    logic [7:0] o_rdata;
    logic [1:0] nak;
    logic [1:0] tog;
    logic [1:0] rcv;
    logic sent;
    logic strobe;
    logic irq0;
    logic irq1;
    logic rd_d = 1'b0;
    logic [7:0] d;
    uepirq_out_ev_t [1:0] ev;
    logic [7:0] exp_q[$];
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'hc1a90c9d;
    always #4 i_clock = ~i_clock;
    uepirq_sie uepirq_sie_inst (.i_clock(i_clock), .o_nak(nak), .o_tog(tog), .o_sent(sent), .o_ev(ev));
    uepirq_top uepirq_top_inst (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bulk_in_nak(nak), .i_bulk_in_toggle(tog),
        .i_bulk_in_fifo_write(fw[1:0]), .i_int_in_sent(sent), .i_int_in_fifo_write(fw[2]),
        .i_out_ev(ev), .i_if_support(i_if_support), .o_endpoint_event_strobe(strobe),
        .o_function_irq_primary(irq0), .o_function_irq_secondary(irq1), .o_out_received(rcv));
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] v);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_clock);
        i_rd <= 1'b0;
    endtask
    task automatic cpu_wr(input logic [2:0] m);
        @(posedge i_clock);
        fw <= m;
        @(posedge i_clock);
        fw <= 3'h0;
    endtask
    task automatic finish_test;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge i_clock) rd_d <= i_rd;
    always @(negedge i_clock) begin
        if (rd_d === 1'b1 && exp_q.size() > 0) begin
            cmp("rdata", exp_q.pop_front(), o_rdata);
        end
    end
    initial begin
        repeat (3000) @(posedge i_clock);
        err_total++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(UEPIRQ_IN_STATUS_ADDR, UEPIRQ_STATUS_RESET);
        rd(UEPIRQ_OUT_STATUS_ADDR, UEPIRQ_STATUS_RESET);
        rd(32'h0020_0040, 8'h00);
        uepirq_sie_inst.pulse(0, 0);
        @(posedge i_clock);
        #1;
        cmp("strobe", 8'h01, {7'h00, strobe});
        rd(UEPIRQ_IN_STATUS_ADDR, 8'h20);
        uepirq_sie_inst.pulse(0, 1);
        uepirq_sie_inst.pulse(1, 0);
        uepirq_sie_inst.pulse(1, 1);
        uepirq_sie_inst.pulse(2, 0);
        d = 8'($random(seed));
        wr(UEPIRQ_IN_STATUS_ADDR, d);
        rd(UEPIRQ_IN_STATUS_ADDR, 8'hf1);
        cpu_wr(3'h1);
        rd(UEPIRQ_IN_STATUS_ADDR, 8'he1);
        cpu_wr(3'h4);
        rd(UEPIRQ_IN_STATUS_ADDR, 8'he0);
        wr(UEPIRQ_IN_CLEAR_ADDR, 8'h7f);
        d = 8'($random(seed));
        wr(UEPIRQ_IN_CLEAR_ADDR, d);
        rd(UEPIRQ_IN_STATUS_ADDR, 8'h60 & d);
        wr(UEPIRQ_IN_CLEAR_ADDR, 8'h00);
        wr(UEPIRQ_IN_MASK_ADDR, 8'h40);
        uepirq_sie_inst.pulse(1, 1);
        rd(UEPIRQ_IN_STATUS_ADDR, 8'h40);
        cmp("irq0", 8'h00, {7'h00, irq0});
        wr(UEPIRQ_IN_MASK_ADDR, 8'h00);
        repeat (3) @(posedge i_clock);
        cmp("irq0", 8'h01, {7'h00, irq0});
        wr(UEPIRQ_IN_CLEAR_ADDR, 8'h00);
        i_if_support <= 5'h16;
        uepirq_sie_inst.pulse(0, 0);
        uepirq_sie_inst.pulse(6, 0);
        rd(UEPIRQ_IN_STATUS_ADDR, 8'h00);
        wr(UEPIRQ_OUT_CLEAR_ADDR, 8'h00);
        uepirq_sie_inst.level(0, 1'b1, 1'b0);
        i_if_support <= 5'h1f;
        uepirq_sie_inst.pulse(3, 0);
        uepirq_sie_inst.pulse(4, 0);
        uepirq_sie_inst.pulse(5, 1);
        rd(UEPIRQ_OUT_STATUS_ADDR, 8'h86);
        wr(UEPIRQ_OUT_CLEAR_ADDR, 8'h00);
        uepirq_sie_inst.pulse(6, 0);
        uepirq_sie_inst.level(0, 1'b0, 1'b1);
        uepirq_sie_inst.pulse(4, 0);
        rd(UEPIRQ_OUT_STATUS_ADDR, 8'h01);
        cmp("received", 8'h01, {6'h00, rcv});
        uepirq_sie_inst.level(0, 1'b1, 1'b1);
        rd(UEPIRQ_OUT_STATUS_ADDR, 8'h04);
        cmp("irq1", 8'h01, {7'h00, irq1});
        uepirq_sie_inst.pulse(5, 1);
        uepirq_sie_inst.pulse(6, 1);
        rd(UEPIRQ_OUT_STATUS_ADDR, 8'h14);
        wr(UEPIRQ_SUPPORT_ADDR, 8'h1e);
        rd(UEPIRQ_SUPPORT_ADDR, 8'h1e);
        rd(UEPIRQ_IN_STATUS_ADDR, 8'h00);
        repeat (4) @(posedge i_clock);
        finish_test;
    end
endmodule // uepirq_top_test
bind uepirq_top uepirq_assertions uepirq_assertions_inst (.i_clock(i_clock), .i_rst(i_rst),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bulk_in_nak(i_bulk_in_nak),
    .i_bulk_in_toggle(i_bulk_in_toggle), .i_bulk_in_fifo_write(i_bulk_in_fifo_write),
    .i_int_in_sent(i_int_in_sent), .i_int_in_fifo_write(i_int_in_fifo_write), .i_out_ev(i_out_ev),
    .i_if_support(i_if_support), .o_endpoint_event_strobe(o_endpoint_event_strobe),
    .o_function_irq_primary(o_function_irq_primary),
    .o_function_irq_secondary(o_function_irq_secondary), .o_out_received(o_out_received));
`default_nettype wire
